// [gtmr_consts.vh]
`ifndef GTMR_CONSTS_VH
`define GTMR_CONSTS_VH
// Register byte addresses on the AXI4-Lite bus
`define GTMR_OFF_CTRL     4'h0
`define GTMR_OFF_GATE     4'h4
`define GTMR_OFF_HIGH     4'h8
`define GTMR_OFF_LOW      4'hC
`define GTMR_OFF_FLAGS    5'h10
// Counter control fields
`define GTMR_CS_HI        7
`define GTMR_CS_LO        6
`define GTMR_PS_HI        5
`define GTMR_PS_LO        4
`define GTMR_SYNC_BIT     2
`define GTMR_ON_BIT       0
`define GTMR_CTRL_WMASK   8'hF5
// Gate control fields
`define GTMR_GE_BIT       7
`define GTMR_POL_BIT      6
`define GTMR_TM_BIT       5
`define GTMR_SPM_BIT      4
`define GTMR_ARM_BIT      3
`define GTMR_VAL_BIT      2
`define GTMR_GSS_HI       1
`define GTMR_GSS_LO       0
// Flag register fields
`define GTMR_FLAG_ROLL    0
`define GTMR_FLAG_GATE    1
// Clock source codes
`define GTMR_CS_INSTR     2'b00
`define GTMR_CS_SYS       2'b01
`define GTMR_CS_EXT       2'b10
`define GTMR_CS_LFOSC     2'b11
// Gate source codes
`define GTMR_GSS_PIN      2'b00
`define GTMR_GSS_T0       2'b01
// Instruction clock divide by four
`define GTMR_INSTR_DIV    2'b11
// AXI responses
`define GTMR_RESP_OKAY    2'b00
`define GTMR_RESP_SLVERR  2'b10
`define GTMR_RESET_BYTE   8'h00
`endif

// [gtmr_edge.v]
`timescale 1ns/10ps
`include "gtmr_consts.vh"
// Optional two-stage synchroniser followed by rising-edge detect
module gtmr_edge
(
   input  wire aclk,
   input  wire aresetn,
   input  wire ce,
   input  wire bypass,
   input  wire din,
   output wire rise
);
   reg meta;  // First stage, read only by stage two
   reg sync;  // Second stage
   reg prev;  // Previous level for edge detect
   wire level;

   // Pick synchronised or direct level
   assign level = bypass ? din : sync;
   assign rise  = level & ~prev;

   // Sample stages
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end
      else if (ce)
      begin
         meta <= din;
         sync <= meta;
         prev <= level;
      end
   end
endmodule

// [gtmr_pins.sv]
`timescale 1ns/10ps
// Far side: external clock, slow oscillator, gate pin, Timer0 overflow
module gtmr_pins
(
   input  wire  aclk,
   output logic ext_clock_pin,
   output logic low_freq_internal_osc,
   output logic gate_input_pin,
   output logic t0_overflow
);
   // All lines idle low; clocks stand still between bursts
   initial
   begin
      ext_clock_pin = 1'b0;
      low_freq_internal_osc = 1'b0;
      gate_input_pin = 1'b0;
      t0_overflow = 1'b0;
   end
   // Burst of n rising edges on the pin clock or the oscillator
   task automatic burst(input int n, input bit osc);
      repeat (n)
      begin
         @(posedge aclk);
         low_freq_internal_osc <= osc;
         ext_clock_pin <= !osc;
         repeat (4) @(posedge aclk);
         low_freq_internal_osc <= 1'b0;
         ext_clock_pin <= 1'b0;
         repeat (3) @(posedge aclk);
      end
   endtask
   // New gate level, held for six clock cycles after it is driven
   task automatic gate(input bit v);
      @(posedge aclk);
      gate_input_pin <= v;
      repeat (6) @(posedge aclk);
   endtask
   // One low-to-high overflow pulse
   task automatic t0_pulse();
      @(posedge aclk);
      t0_overflow <= 1'b1;
      repeat (3) @(posedge aclk);
      t0_overflow <= 1'b0;
      repeat (6) @(posedge aclk);
   endtask
endmodule

// [gtmr_top.v]
`timescale 1ns/10ps
`include "gtmr_consts.vh"
// Functional notes
// - Source field picks instr, system, pin, LFOSC
// - Prescale divides by 1, 2, 4, 8
// - Sync bit clear synchronises async clocks
// - Counter-on enables; off clears gate flip-flop
// - Gate enable ignored off; else gates counting
// - Polarity picks active gate level
// - Toggle bit routes gate; clear zeroes flop
// - Toggle flop flips each gate rising edge
// - Single-pulse bit puts acquisition in control
// - Arm bit reads 1 waiting, 0 done
// - Gate level readable, independent of enable
// - Gate source: pin or Timer0 overflow pulse
// - Control bits 3 and 1 read zero
// - Writable bits reset to zero
// - Count visible as high and low bytes
// - Rollover sets sticky rollover flag
// - Gate level falling edge sets gate flag
// - Arm clears at pulse end; no more counting
// - Timer0 overflow becomes rising gate pulse
module gtmr_top
#(
   parameter CNT_W = 16
)
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        ce,
   input  wire        ext_clock_pin,
   input  wire        low_freq_internal_osc,
   input  wire        gate_input_pin,
   input  wire        t0_overflow,
   input  wire [4:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [4:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output wire        rollover_flag,
   output wire        gate_event_flag
);
   reg  [7:0]       counter_control;  // Clock, prescale, sync, on
   reg  [7:0]       gate_control;     // Gate bits; level bit is live
   reg  [CNT_W-1:0] count;            // The count itself
   reg  [2:0]       presc;            // Prescale counter
   reg  [1:0]       instr_div;        // Divide-by-four for instr clock
   reg              toggle_ff;        // Gate toggle flip-flop
   reg              gate_prev;        // Gate level after polarity, last cycle
   reg              level_prev;       // Gate level status, last cycle
   reg              t0_prev;          // Timer0 overflow, last cycle
   reg              flag_roll;        // Sticky rollover
   reg              flag_gate;        // Sticky gate event
   reg              aw_held;          // Write address captured
   reg  [4:0]       aw_addr;
   reg              w_held;           // Write data captured
   reg  [31:0]      w_data;
   reg  [3:0]       w_strb;
   wire             ext_rise;
   wire             osc_rise;
   wire             on;
   wire             gate_src;
   wire             gate_pol;
   wire             gate_level;
   wire             spm_window;
   reg              clk_edge;
   reg              tick;
   wire             inc;
   wire             wr_go;
   wire             gate_fall;
   wire             roll;
   wire [CNT_W-1:0] next_count;

   assign on = counter_control[`GTMR_ON_BIT];

   // External pin and oscillator, synchronised unless bypassed
   gtmr_edge u_ext
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .bypass  (counter_control[`GTMR_SYNC_BIT]),
      .din     (ext_clock_pin),
      .rise    (ext_rise)
   );
   gtmr_edge u_osc
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .bypass  (counter_control[`GTMR_SYNC_BIT]),
      .din     (low_freq_internal_osc),
      .rise    (osc_rise)
   );

   // Clock source mux
   always @*
   begin
      case (counter_control[`GTMR_CS_HI:`GTMR_CS_LO])
         `GTMR_CS_INSTR: clk_edge = (instr_div == `GTMR_INSTR_DIV);
         `GTMR_CS_SYS:   clk_edge = 1'b1;
         `GTMR_CS_EXT:   clk_edge = ext_rise;
         `GTMR_CS_LFOSC: clk_edge = osc_rise;
         default:        clk_edge = 1'b0;
      endcase
   end

   // Prescaler tap selection
   always @*
   begin
      case (counter_control[`GTMR_PS_HI:`GTMR_PS_LO])
         2'b00:   tick = clk_edge;
         2'b01:   tick = clk_edge & (presc[0] == 1'b1);
         2'b10:   tick = clk_edge & (presc[1:0] == 2'b11);
         2'b11:   tick = clk_edge & (presc == 3'b111);
         default: tick = 1'b0;
      endcase
   end

   // Gate source: pin, or Timer0 overflow made into a rising pulse
   assign gate_src = (gate_control[`GTMR_GSS_HI:`GTMR_GSS_LO] == `GTMR_GSS_T0)
                     ? (t0_overflow & ~t0_prev)
                     : (gate_control[`GTMR_GSS_HI:`GTMR_GSS_LO] == `GTMR_GSS_PIN)
                       & gate_input_pin;
   // Polarity, then optional toggle
   assign gate_pol   = gate_control[`GTMR_POL_BIT] ? gate_src : ~gate_src;
   assign spm_window = ~gate_control[`GTMR_SPM_BIT] | gate_control[`GTMR_ARM_BIT];
   assign gate_level = (gate_control[`GTMR_TM_BIT] ? toggle_ff : gate_pol)
                       & spm_window;
   assign gate_fall  = level_prev & ~gate_level;
   assign inc = on & tick & (~gate_control[`GTMR_GE_BIT] | gate_level);
   assign next_count = count + {{(CNT_W-1){1'b0}}, 1'b1};
   assign roll = inc & (count == {CNT_W{1'b1}});

   assign rollover_flag   = flag_roll;
   assign gate_event_flag = flag_gate;

   // Bus handshakes: each channel taken once until the response
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign wr_go = aw_held & w_held;

   // Divider, prescaler, gate state and count
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         instr_div  <= 2'b00;
         presc      <= 3'b000;
         toggle_ff  <= 1'b0;
         gate_prev  <= 1'b0;
         level_prev <= 1'b0;
         t0_prev    <= 1'b0;
         count      <= {CNT_W{1'b0}};
         flag_roll  <= 1'b0;
         flag_gate  <= 1'b0;
      end
      else if (ce)
      begin
         instr_div  <= instr_div + 2'b01;
         gate_prev  <= gate_pol;
         level_prev <= gate_level;
         t0_prev    <= t0_overflow;
         // Prescaler runs only while on
         if (!on)
            presc <= 3'b000;
         else if (clk_edge)
            presc <= presc + 3'b001;
         // Toggle flop: cleared when off or toggle disabled
         if (!on || !gate_control[`GTMR_TM_BIT])
            toggle_ff <= 1'b0;
         else if (gate_pol && !gate_prev)
            toggle_ff <= ~toggle_ff;
         // Count: software write of a byte wins over increment
         if (wr_go && aw_addr == `GTMR_OFF_HIGH && w_strb[0])
            count[CNT_W-1:8] <= w_data[CNT_W-9:0];
         else if (wr_go && aw_addr == `GTMR_OFF_LOW && w_strb[0])
            count[7:0] <= w_data[7:0];
         else if (inc)
            count <= next_count;
         // Sticky flags, set wins over write-one clear
         if (roll)
            flag_roll <= 1'b1;
         else if (wr_go && aw_addr == `GTMR_OFF_FLAGS && w_strb[0]
                  && w_data[`GTMR_FLAG_ROLL])
            flag_roll <= 1'b0;
         if (gate_fall)
            flag_gate <= 1'b1;
         else if (wr_go && aw_addr == `GTMR_OFF_FLAGS && w_strb[0]
                  && w_data[`GTMR_FLAG_GATE])
            flag_gate <= 1'b0;
      end
   end

   // Control registers and write channel
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         counter_control <= `GTMR_RESET_BYTE;
         gate_control    <= `GTMR_RESET_BYTE;
         aw_held         <= 1'b0;
         aw_addr         <= 5'h00;
         w_held          <= 1'b0;
         w_data          <= 32'h0000_0000;
         w_strb          <= 4'h0;
         s_axi_bvalid    <= 1'b0;
         s_axi_bresp     <= `GTMR_RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         // Arm clears on trailing edge of the acquired pulse
         if (gate_control[`GTMR_SPM_BIT] && gate_control[`GTMR_ARM_BIT] && gate_fall)
            gate_control[`GTMR_ARM_BIT] <= 1'b0;
         if (wr_go)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `GTMR_RESP_OKAY;
            case (aw_addr)
               `GTMR_OFF_CTRL:
                  if (w_strb[0])
                     counter_control <= w_data[7:0] & `GTMR_CTRL_WMASK;
               `GTMR_OFF_GATE:
                  if (w_strb[0])
                  begin
                     gate_control[7:4] <= w_data[7:4];
                     gate_control[1:0] <= w_data[1:0];
                     // Arm cannot be set back while a pulse is ending
                     if (!(gate_fall && gate_control[`GTMR_SPM_BIT]))
                        gate_control[`GTMR_ARM_BIT] <= w_data[`GTMR_ARM_BIT];
                  end
               `GTMR_OFF_HIGH, `GTMR_OFF_LOW, `GTMR_OFF_FLAGS:
                  s_axi_bresp <= `GTMR_RESP_OKAY;
               default:
                  s_axi_bresp <= `GTMR_RESP_SLVERR;
            endcase
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `GTMR_RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `GTMR_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            case (s_axi_araddr)
               `GTMR_OFF_CTRL:
                  s_axi_rdata[7:0] <= counter_control;
               `GTMR_OFF_GATE:
                  s_axi_rdata[7:0] <= {gate_control[7:3], gate_level,
                                       gate_control[1:0]};
               `GTMR_OFF_HIGH:
                  s_axi_rdata[7:0] <= count[CNT_W-1:8];
               `GTMR_OFF_LOW:
                  s_axi_rdata[7:0] <= count[7:0];
               `GTMR_OFF_FLAGS:
                  s_axi_rdata[1:0] <= {flag_gate, flag_roll};
               default:
                  s_axi_rresp <= `GTMR_RESP_SLVERR;
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// [gtmr_top_props.sv]
`timescale 1ns/10ps
`include "gtmr_consts.vh"
// Port checker: bus answers, read-back fields, flag clearing
module gtmr_top_props
#(
   parameter CNT_W = 16
)
(
   input wire        aclk,
   input wire        aresetn,
   input wire        ce,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [4:0]  s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        rollover_flag,
   input wire        gate_event_flag
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   reg [4:0] rd_addr;  // Address of the read in flight
   // Keep the address of each accepted read
   always @(posedge aclk)
   begin
      if (!aresetn)
         rd_addr <= 5'h00;
      else if (s_axi_arvalid && s_axi_arready && ce)
         rd_addr <= s_axi_araddr;
   end
   // Read address accepted
   sequence ar_take;
      s_axi_arvalid && s_axi_arready && ce;
   endsequence
   // Write address and data accepted together
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
   endsequence
   rd_answer_a: assert property (ar_take |=> s_axi_rvalid)
      else $error("read not answered");
   wr_answer_a: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response timing wrong");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
   wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while answer pending");
   ctrl_zero_a: assert property (s_axi_rvalid && rd_addr == `GTMR_OFF_CTRL |->
      !s_axi_rdata[3] && !s_axi_rdata[1]) else $error("unused control bits set");
   bad_addr_a: assert property (s_axi_rvalid && rd_addr[4:2] > 3'h4 |->
      s_axi_rresp == `GTMR_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   roll_clear_a: assert property ($fell(rollover_flag) |-> $rose(s_axi_bvalid))
      else $error("rollover flag cleared without a write");
   gate_clear_a: assert property ($fell(gate_event_flag) |-> $rose(s_axi_bvalid))
      else $error("gate flag cleared without a write");
endmodule

// [gtmr_top_test.sv]
`timescale 1ns/10ps
`include "gtmr_consts.vh"
// Register-level bench for the gated timer
module gtmr_top_test;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [4:0]  s_axi_awaddr = 5'h00;
   logic [4:0]  s_axi_araddr = 5'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        ce = 1'b1;            // Clock enable, lowered once to check freezing
   logic [3:0]  s_axi_wstrb = 4'h1;  // Write strobes, cleared once to check refusal
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire         ext_clock_pin, low_freq_internal_osc, gate_input_pin, t0_overflow;
   wire         rollover_flag, gate_event_flag;
   logic [31:0] d;            // Last read value
   int          miscompares = 0;
   int          n_compared = 0;
   int          cycles = 0;    // Run length guard
   gtmr_top uut (.aclk, .aresetn, .ce, .ext_clock_pin, .low_freq_internal_osc,
      .gate_input_pin, .t0_overflow, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rollover_flag,
      .gate_event_flag);
   gtmr_pins pins (.aclk, .ext_clock_pin, .low_freq_internal_osc, .gate_input_pin,
      .t0_overflow);
   // 4 ns clock
   initial
   begin
      forever #2 aclk = !aclk;
   end
   // Verdict and end of run
   task final_report();
      if (miscompares == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Compare and count
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Bus write; each channel drops once taken, bready stands until bvalid is seen
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   // Bus read into d; rready stands until rvalid is seen, data taken at that edge
   task automatic rd(input logic [4:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask
   // Hang guard
   always @(posedge aclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         miscompares++;
         final_report();
      end
   end
   // Main sequence
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      // Gate pin idles low and polarity resets to active low, so the live level reads 1
      for (int i = 0; i < 5; i++)
      begin
         rd(5'(i * 4));
         chk(d, (i == 1) ? 32'h0000_0004 : 32'h0000_0000);
      end
      wr(`GTMR_OFF_CTRL, 8'h0A);
      rd(`GTMR_OFF_CTRL);
      chk(d, 32'h0000_0000);
      wr(`GTMR_OFF_HIGH, 8'hA5);
      wr(`GTMR_OFF_LOW, 8'h3C);
      rd(`GTMR_OFF_HIGH);
      chk(d, 32'h0000_00A5);
      rd(`GTMR_OFF_LOW);
      chk(d, 32'h0000_003C);
      // A write without its byte strobe leaves the count alone
      s_axi_wstrb <= 4'h0;
      wr(`GTMR_OFF_LOW, 8'h55);
      s_axi_wstrb <= 4'h1;
      rd(`GTMR_OFF_LOW);
      chk(d, 32'h0000_003C);
      // Pin clock through every prescale, synchronised and direct
      for (int m = 0; m < 8; m++)
      begin
         wr(`GTMR_OFF_LOW, 8'h00);
         wr(`GTMR_OFF_CTRL, {2'b10, 2'(m), 1'b0, m[2], 2'b01});
         pins.burst(16, 1'b0);
         wr(`GTMR_OFF_CTRL, 8'h00);
         rd(`GTMR_OFF_LOW);
         chk(d, 32'(16 >> m[1:0]));
      end
      wr(`GTMR_OFF_LOW, 8'h00);
      wr(`GTMR_OFF_CTRL, 8'hC1);
      pins.burst(8, 1'b1);
      wr(`GTMR_OFF_CTRL, 8'hC0);
      rd(`GTMR_OFF_LOW);
      chk(d, 32'h0000_0008);
      // Instruction clock: four enabled cycles while on give one tick; ce low freezes
      wr(`GTMR_OFF_LOW, 8'h00);
      wr(`GTMR_OFF_CTRL, 8'h01);
      ce <= 1'b0;
      repeat (4) @(posedge aclk);
      ce <= 1'b1;
      wr(`GTMR_OFF_CTRL, 8'h00);
      rd(`GTMR_OFF_LOW);
      chk(d, 32'h0000_0001);
      // Rollover on the system clock, then clear the flag
      wr(`GTMR_OFF_HIGH, 8'hFF);
      wr(`GTMR_OFF_LOW, 8'hFF);
      wr(`GTMR_OFF_CTRL, 8'h41);
      wr(`GTMR_OFF_CTRL, 8'h00);
      chk(32'(rollover_flag), 32'h0000_0001);
      rd(`GTMR_OFF_HIGH);
      chk(d, 32'h0000_0000);
      wr(`GTMR_OFF_FLAGS, 8'h01);
      chk(32'(rollover_flag), 32'h0000_0000);
      // Gate enable, polarity and pin level combinations
      for (int m = 0; m < 8; m++)
      begin
         pins.gate(m[1]);
         wr(`GTMR_OFF_GATE, {m[2], m[0], 6'h00});
         wr(`GTMR_OFF_LOW, 8'h00);
         wr(`GTMR_OFF_CTRL, 8'h81);
         pins.burst(8, 1'b0);
         rd(`GTMR_OFF_GATE);
         chk(32'(d[2]), 32'(m[0] == m[1]));
         wr(`GTMR_OFF_CTRL, 8'h00);
         rd(`GTMR_OFF_LOW);
         chk(d, 32'((!m[2] || m[0] == m[1]) ? 8 : 0));
      end
      // Toggle mode: one full gate cycle per flip
      pins.gate(1'b0);
      wr(`GTMR_OFF_CTRL, 8'h81);
      wr(`GTMR_OFF_GATE, 8'h60);
      wr(`GTMR_OFF_FLAGS, 8'h02);
      for (int k = 1; k < 4; k++)
      begin
         pins.gate(1'b1);
         pins.gate(1'b0);
         rd(`GTMR_OFF_GATE);
         chk(32'(d[2]), 32'(k % 2));
      end
      chk(32'(gate_event_flag), 32'h0000_0001);
      wr(`GTMR_OFF_CTRL, 8'h80);
      rd(`GTMR_OFF_GATE);
      chk(32'(d[2]), 32'h0000_0000);
      // Single pulse: closed until armed, arm clears after the pulse
      wr(`GTMR_OFF_CTRL, 8'h81);
      wr(`GTMR_OFF_GATE, 8'hD0);
      pins.gate(1'b1);
      rd(`GTMR_OFF_GATE);
      chk(32'(d[2]), 32'h0000_0000);
      pins.gate(1'b0);
      wr(`GTMR_OFF_GATE, 8'hD8);
      rd(`GTMR_OFF_GATE);
      chk(32'(d[3]), 32'h0000_0001);
      pins.gate(1'b1);
      pins.gate(1'b0);
      rd(`GTMR_OFF_GATE);
      chk(32'(d[3]), 32'h0000_0000);
      // Timer0 overflow as gate source through the toggle
      wr(`GTMR_OFF_GATE, 8'h61);
      pins.t0_pulse();
      rd(`GTMR_OFF_GATE);
      chk(32'(d[2]), 32'h0000_0001);
      rd(5'h14);
      chk(d, 32'h0000_0000);
      final_report();
   end
endmodule
bind gtmr_top gtmr_top_props #(.CNT_W(CNT_W)) props_i (.aclk, .aresetn, .ce,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rollover_flag,
   .gate_event_flag);
